//--- logic/dmaes_top.sv
`timescale 1ns/1ps

module dmaes_top (
  input  wire logic                       mclk,       // Bus clock
  input  wire logic                       rst,        // Async reset
  input  wire logic                       hsel,       // Slave select
  input  wire logic [31:0]                haddr,      // Byte address
  input  wire logic [1:0]                 htrans,     // Transfer type
  input  wire logic                       hwrite,     // Write when high
  input  wire logic [2:0]                 hsize,      // Access size
  input  wire logic                       hready,     // Bus ready in
  input  wire logic [31:0]                hwdata,     // Write data
  output logic      [31:0]                hrdata,     // Read data
  output logic                            hreadyout,  // Slave ready
  output logic                            hresp,      // Error response
  input  wire dmaes_pkg::dmaes_evt_s      evt,        // Engine event strobes
  input  wire logic [dmaes_pkg::NCH-1:0]  periph_req, // Peripheral requests
  input  wire logic                       adc_req,    // Converter request
  output dmaes_pkg::dmaes_chan_s          chan        // Channel controls
);

  // ****************************************
  // State
  // ****************************************
  dmaes_pkg::dmaes_state_s st_q;
  dmaes_pkg::dmaes_state_s st_d;

  logic [dmaes_pkg::NCH-1:0][dmaes_pkg::FPC-1:0] clr_w;
  logic [5:0]                                    idx_w;
  logic [2:0]                                    cidx_w;
  logic [2:0]                                    rcidx_w;
  logic                                          accept_w;
  logic                                          bad_w;
  logic                                          mapped_w;
  logic                                          any_w;

  assign idx_w    = haddr[7:2];
  assign accept_w = hsel & htrans[1] & hready;
  assign mapped_w = (haddr[31:8] == dmaes_pkg::BASE_ADDR[31:8]);
  // Narrow or misaligned accesses are refused outright
  assign bad_w    = (hsize != dmaes_pkg::HSIZE_WORD) | (haddr[1:0] != 2'h0);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d    = st_q;
    clr_w   = '0;
    cidx_w  = 3'(st_q.wr_idx - dmaes_pkg::IDX_CFG0);
    rcidx_w = 3'(idx_w - dmaes_pkg::IDX_CFG0);
    any_w   = 1'b0;

    // Write data phase of the previously accepted write
    if (st_q.wr_pend) begin
      case (st_q.wr_idx)
        dmaes_pkg::IDX_CLEAR: begin
          clr_w = hwdata;
        end
        dmaes_pkg::IDX_RSEL: begin
          st_d.rsel = hwdata[dmaes_pkg::NCH-1:0];
        end
        default: begin
          if (st_q.wr_idx >= dmaes_pkg::IDX_CFG0 &&
              st_q.wr_idx < dmaes_pkg::IDX_CFG0 + 6'(dmaes_pkg::NCH)) begin
            st_d.cfg[cidx_w] = hwdata[3:0];
          end
        end
      endcase
    end

    // Per-channel flags, stop, interrupt and request select
    for (int c = 0; c < dmaes_pkg::NCH; c++) begin
      // Set beats clear so that no event is lost
      st_d.flags[c][dmaes_pkg::FLD_DONE] = evt.done[c] |
        (st_q.flags[c][dmaes_pkg::FLD_DONE] & ~clr_w[c][dmaes_pkg::FLD_DONE]);
      st_d.flags[c][dmaes_pkg::FLD_HALF] = evt.half[c] |
        (st_q.flags[c][dmaes_pkg::FLD_HALF] & ~clr_w[c][dmaes_pkg::FLD_HALF]);
      st_d.flags[c][dmaes_pkg::FLD_ERR]  = evt.fault[c] |
        (st_q.flags[c][dmaes_pkg::FLD_ERR] & ~clr_w[c][dmaes_pkg::FLD_ERR]);
      any_w = evt.done[c] | evt.half[c] | evt.fault[c];
      st_d.flags[c][dmaes_pkg::FLD_ANY]  = any_w |
        (st_q.flags[c][dmaes_pkg::FLD_ANY] & ~clr_w[c][dmaes_pkg::FLD_ANY]);

      // Hardware stop overrides a software enable in the same cycle
      if (evt.fault[c]) begin
        st_d.cfg[c][dmaes_pkg::CFG_EN] = 1'b0;
      end
      st_d.chan.enable[c] = st_d.cfg[c][dmaes_pkg::CFG_EN];

      st_d.chan.irq[c] =
        (st_d.flags[c][dmaes_pkg::FLD_DONE] & st_d.cfg[c][dmaes_pkg::CFG_DONE_IE]) |
        (st_d.flags[c][dmaes_pkg::FLD_HALF] & st_d.cfg[c][dmaes_pkg::CFG_HALF_IE]) |
        (st_d.flags[c][dmaes_pkg::FLD_ERR]  & st_d.cfg[c][dmaes_pkg::CFG_ERR_IE]);

      st_d.chan.request[c] = st_q.rsel[c] ? adc_req : periph_req[c];
    end

    // Address phase and response
    st_d.wr_pend = 1'b0;
    st_d.hready  = 1'b1;
    st_d.hresp   = dmaes_pkg::RESP_OKAY;
    st_d.hrdata  = '0;
    case (st_q.bus)
      dmaes_pkg::BUS_ERR_WAIT: begin
        // Second cycle of the two-cycle error answer
        st_d.bus    = dmaes_pkg::BUS_ERR_LAST;
        st_d.hresp  = dmaes_pkg::RESP_ERROR;
      end
      dmaes_pkg::BUS_RUN, dmaes_pkg::BUS_ERR_LAST: begin
        st_d.bus = dmaes_pkg::BUS_RUN;
        if (accept_w) begin
          if (bad_w) begin
            st_d.bus    = dmaes_pkg::BUS_ERR_WAIT;
            st_d.hready = 1'b0;
            st_d.hresp  = dmaes_pkg::RESP_ERROR;
          end else if (hwrite) begin
            // Status is read only, so a write to it is dropped quietly
            st_d.wr_pend = mapped_w;
            st_d.wr_idx  = idx_w;
          end else if (mapped_w) begin
            // Read the post-update view so a read after a write is fresh
            case (idx_w)
              dmaes_pkg::IDX_STATUS: begin
                st_d.hrdata = st_d.flags;
              end
              dmaes_pkg::IDX_CLEAR: begin
                st_d.hrdata = '0;
              end
              dmaes_pkg::IDX_RSEL: begin
                st_d.hrdata = {24'h00_0000, st_d.rsel};
              end
              default: begin
                if (idx_w >= dmaes_pkg::IDX_CFG0 &&
                    idx_w < dmaes_pkg::IDX_CFG0 + 6'(dmaes_pkg::NCH)) begin
                  st_d.hrdata = {28'h000_0000, st_d.cfg[rcidx_w]};
                end
              end
            endcase
          end
        end
      end
      default: begin
        st_d.bus = dmaes_pkg::BUS_RUN;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q.flags        <= {dmaes_pkg::NCH{dmaes_pkg::FLAGS_RST}};
      st_q.cfg          <= {dmaes_pkg::NCH{dmaes_pkg::CFG_RST}};
      st_q.rsel         <= dmaes_pkg::RSEL_RST;
      st_q.wr_pend      <= 1'b0;
      st_q.wr_idx       <= 6'h00;
      st_q.bus          <= dmaes_pkg::BUS_RUN;
      st_q.hready       <= 1'b1;
      st_q.hresp        <= dmaes_pkg::RESP_OKAY;
      st_q.hrdata       <= 32'h0000_0000;
      st_q.chan         <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hrdata    = st_q.hrdata;
  assign hreadyout = st_q.hready;
  assign hresp     = st_q.hresp;
  assign chan      = st_q.chan;

endmodule : dmaes_top

//--- common/dmaes_pkg.sv
package dmaes_pkg;

  // ****************************************
  // Geometry and map
  // ****************************************
  localparam int          NCH        = 8;
  localparam int          FPC        = 4;
  localparam logic [31:0] BASE_ADDR  = 32'hA000_0000;
  localparam logic [5:0]  IDX_STATUS = 6'h00;
  localparam logic [5:0]  IDX_CLEAR  = 6'h01;
  localparam logic [5:0]  IDX_RSEL   = 6'h02;
  localparam logic [5:0]  IDX_CFG0   = 6'h04;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         FLD_ANY     = 0;
  localparam int         FLD_DONE    = 1;
  localparam int         FLD_HALF    = 2;
  localparam int         FLD_ERR     = 3;
  localparam int         CFG_EN      = 0;
  localparam int         CFG_DONE_IE = 1;
  localparam int         CFG_HALF_IE = 2;
  localparam int         CFG_ERR_IE  = 3;
  localparam logic [3:0] FLAGS_RST   = 4'h0;
  localparam logic [3:0] CFG_RST     = 4'h0;
  localparam logic [7:0] RSEL_RST    = 8'h00;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       RESP_OKAY  = 1'b0;
  localparam logic       RESP_ERROR = 1'b1;

  typedef enum logic [1:0] {
    BUS_RUN      = 2'b00,
    BUS_ERR_WAIT = 2'b01,
    BUS_ERR_LAST = 2'b10
  } dmaes_bus_e;

  typedef struct packed {
    logic [NCH-1:0] half;
    logic [NCH-1:0] done;
    logic [NCH-1:0] fault;
  } dmaes_evt_s;

  typedef struct packed {
    logic [NCH-1:0] enable;
    logic [NCH-1:0] request;
    logic [NCH-1:0] irq;
  } dmaes_chan_s;

  typedef struct packed {
    logic [NCH-1:0][FPC-1:0] flags;
    logic [NCH-1:0][3:0]     cfg;
    logic [NCH-1:0]          rsel;
    logic                    wr_pend;
    logic [5:0]              wr_idx;
    dmaes_bus_e              bus;
    logic                    hready;
    logic                    hresp;
    logic [31:0]             hrdata;
    dmaes_chan_s             chan;
  } dmaes_state_s;

endpackage : dmaes_pkg

//--- sim/dmaes_props.sv
`timescale 1ns/1ps
module dmaes_props (
  input wire logic                     mclk,       // Clock
  input wire logic                     rst,        // Reset
  input wire logic                     hsel,       // Select
  input wire logic [31:0]              haddr,      // Address
  input wire logic [1:0]               htrans,     // Type
  input wire logic                     hwrite,     // Write
  input wire logic [2:0]               hsize,      // Size
  input wire logic                     hready,     // Ready in
  input wire logic [31:0]              hrdata,     // Read data
  input wire logic                     hreadyout,  // Ready out
  input wire logic                     hresp,      // Error
  input wire dmaes_pkg::dmaes_evt_s    evt,        // Events
  input wire logic [dmaes_pkg::NCH-1:0] periph_req, // Requests
  input wire logic                     adc_req,    // Converter
  input wire dmaes_pkg::dmaes_chan_s   chan        // Channels
);
  // ****************************************
  // Bus and channel checks
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic tk;
  logic ok;
  logic rd_q;
  assign tk = hsel & htrans[1] & hready;
  assign ok = hsize == dmaes_pkg::HSIZE_WORD && haddr[1:0] == 2'h0;
  always_ff @(posedge mclk or posedge rst)
    if (rst) rd_q <= 1'b0;
    else rd_q <= tk & ok & !hwrite;
  a_err_answer: assert property (tk && !ok |=> !hreadyout && hresp ##1 hreadyout && hresp)
    else $error("bad error answer");
  a_ok_answer: assert property (tk && ok |=> hreadyout && !hresp)
    else $error("bad okay answer");
  a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait too long");
  a_idle_zero: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data not zero");
  a_clear_zero: assert property (tk && ok && !hwrite && haddr == 32'hA000_0004 |=> hrdata == 32'h0000_0000)
    else $error("clear read not zero");
  a_unmapped_zero: assert property (tk && ok && haddr[31:8] != 24'hA0_0000 |=> hrdata == 0 && !hresp)
    else $error("unmapped access answered");
  a_fault_stops: assert property (|evt.fault |=> (chan.enable & $past(evt.fault)) == 8'h00)
    else $error("faulted channel still enabled");
  a_req_select: assert property (periph_req == {8{adc_req}} |=> chan.request == $past(periph_req))
    else $error("request select wrong");
endmodule : dmaes_props

bind dmaes_top dmaes_props u_props (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
  .hrdata, .hreadyout, .hresp, .evt, .periph_req, .adc_req, .chan);

//--- sim/dmaes_eng_model.sv
`timescale 1ns/1ps
module dmaes_eng_model (
  input  wire logic                 mclk,       // Clock
  output dmaes_pkg::dmaes_evt_s     evt,        // Event strobes
  output logic [dmaes_pkg::NCH-1:0] periph_req, // Peripheral requests
  output logic                      adc_req     // Converter request
);
  initial begin
    evt = '0;
    periph_req = '0;
    adc_req = 1'b0;
  end
  // Strobe lasts one cycle so each event is counted once
  task pulse(input dmaes_pkg::dmaes_evt_s e);
    @(negedge mclk);
    evt = e;
    @(negedge mclk);
    evt = '0;
  endtask : pulse
  task reqs(input logic [7:0] p, input logic a);
    @(negedge mclk);
    periph_req = p;
    adc_req = a;
  endtask : reqs
endmodule : dmaes_eng_model

//--- sim/test_dmaes_top.sv
`timescale 1ns/1ps
module test_dmaes_top;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, e, areq;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] preq;
  dmaes_pkg::dmaes_evt_s evt;
  dmaes_pkg::dmaes_chan_s chan;
  int fails = 0, comparisons = 0, cyc = 0;
  localparam logic [31:0] B = dmaes_pkg::BASE_ADDR;
  always #2.5 mclk = ~mclk;
  dmaes_top dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .evt, .periph_req(preq), .adc_req(areq), .chan);
  dmaes_eng_model eng (.mclk, .evt, .periph_req(preq), .adc_req(areq));
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask : chk
  // Error answer takes two cycles, so wait out its tail
  task bus(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d);
    @(negedge mclk);
    {hsel, htrans, hwrite, haddr, hsize} = {1'b1, 2'h2, w, a, s};
    @(negedge mclk);
    {hsel, htrans, hwdata, r, e} = {1'b0, 2'h0, d, hrdata, hresp};
    if (e) begin
      chk("ready", 0, hreadyout);
      @(negedge mclk);
    end
  endtask : bus
  task rd(input logic [31:0] a, input logic [31:0] x, input string n);
    bus(0, a, 2, 0);
    chk(n, x, r);
  endtask : rd
  task t_flags;
    rd(B, 0, "st_rst");
    rd(B + 4, 0, "clr_rst");
    eng.pulse('{half: 8'h00, done: 8'h04, fault: 8'h08});
    eng.pulse('{half: 8'h20, done: 8'h00, fault: 8'h00});
    rd(B, 32'h0050_9300, "flags");
    bus(1, B, 2, '1);
    rd(B, 32'h0050_9300, "ro");
    bus(1, B + 4, 2, 0);
    rd(B, 32'h0050_9300, "clr0");
    bus(1, B + 4, 2, 32'h0000_0200);
    rd(B, 32'h0050_9100, "clr1");
    bus(1, B + 4, 2, '1);
    rd(B, 0, "clr_all");
    $display("t_flags done");
  endtask : t_flags
  task t_irq;
    bus(1, B + 32'h14, 2, 32'h9);
    bus(1, B + 32'h20, 2, 32'h5);
    // Config lands at the edge after the data phase
    @(negedge mclk);
    chk("en_on", 8'h12, chan.enable);
    eng.pulse('{half: 8'h00, done: 8'h00, fault: 8'h12});
    chk("en_off", 8'h00, chan.enable);
    chk("irq_err", 8'h02, chan.irq);
    eng.pulse('{half: 8'h10, done: 8'h00, fault: 8'h00});
    chk("irq_half", 8'h12, chan.irq);
    bus(1, B + 4, 2, 32'h0004_0000);
    rd(B, 32'h0009_0090, "st_err");
    chk("irq_clr", 8'h02, chan.irq);
    $display("t_irq done");
  endtask : t_irq
  task t_req;
    bus(1, B + 8, 2, 32'h0F);
    eng.reqs(8'hA5, 1);
    @(negedge mclk);
    chk("req_adc", 8'hAF, chan.request);
    eng.reqs(8'hA5, 0);
    @(negedge mclk);
    chk("req_per", 8'hA0, chan.request);
    $display("t_req done");
  endtask : t_req
  task t_err;
    bus(0, B, 0, 0);
    chk("byte", 1, e);
    bus(1, B + 4, 1, '1);
    chk("half", 1, e);
    rd(B, 32'h0009_0090, "no_eff");
    rd(32'hA000_0100, 0, "unmap");
    $display("t_err done");
  endtask : t_err
  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    t_flags;
    t_irq;
    t_req;
    t_err;
    test_done;
  end
endmodule : test_dmaes_top
